/* core/cvd_phase_timer.sv */
`timescale 1ns/10ps
// Down-counter that times one phase in converter clock cycles
module cvd_phase_timer
  import cvd_pkg::*;
#(
  parameter int WIDTH = LEN_W
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] length,
  // Status
  output logic                  expired
);

  logic [WIDTH-1:0] count;

  // Load at phase start, count down and hold at zero; expired at one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (load) begin
      count <= length;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign expired = count == {{(WIDTH-1){1'b0}}, 1'b1};

endmodule : cvd_phase_timer

/* core/cvd_pkg.sv */
package cvd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PRE    = 8'h04;
  localparam logic [7:0] ADDR_ACQ    = 8'h08;
  localparam logic [7:0] ADDR_CAP    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CONV   = 8'h14;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int LEN_W = 13;
  localparam int CAP_W = 5;
  localparam int CONV_W = 8;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_LEVEL  = 1;
  localparam int CTRL_GIDLE  = 2;
  localparam int CTRL_INVERT = 3;
  localparam int CTRL_DUAL   = 4;
  localparam int CTRL_ON     = 5;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [LEN_W-1:0]  LEN_MAX       = 13'h1fff;
  localparam logic [CONV_W-1:0] CONV_DEFAULT  = 8'h0f;
  localparam logic [1:0]        RESP_OKAY     = 2'h0;
  localparam logic [1:0]        RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_ACQ   = 3'b010,
    ST_CONV  = 3'b011
  } cvd_state_type;

endpackage : cvd_pkg

/* core/cvd_precharge_acq_sequencer.sv */
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Precharge enabled only for nonzero precharge length
// - Any conversion start begins precharge when precharge length is nonzero
// - Zero precharge length skips precharge
// - Precharge isolates and ties sample capacitor by level
// - Precharge forces channel pin drive high/low
// - Sensor path precharged opposite capacitor level
// - Precharge lasts precharge length cycles
// - Pin override beats pin direction control
// - Acquisition follows precharge, lasts window length
// - Acquisition releases drivers, connects channel
// - Zero window with precharge means 8191
// - Zero window without precharge: no timed acquisition
// - Differential repeats sequence with inverted levels
// - Two guard outputs, polarity from idle/invert
// - First precharge sets guards to idle level
// - Acquisition inverts guard A only; first acquisition with zero precharge length leaves A at idle level
// - Second sample invert flips guards, toggles A; no flip when precharge length is zero
// - Extra capacitance parallel, removed during conversion
// - No automatic capacitor discharge after conversion
// - Acquisition completes before conversion starts
// - Dual-sample bit selects one or two samples
module cvd_precharge_acq_sequencer
  import cvd_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Hardware triggers (same clock domain)
  input  wire logic              special_trigger,
  input  wire logic              restart_trigger,
  // Pin direction control of selected channel (1 = input)
  input  wire logic              pin_direction_control,
  // Sample capacitor switches
  output logic                   hold_isolate,
  output logic                   hold_tie_supply,
  output logic                   hold_tie_ground,
  output logic                   channel_connect,
  // Selected pin driver
  output logic                   pin_out,
  output logic                   pin_oe,
  // Guard ring drives
  output logic                   guard_drive_a,
  output logic                   guard_drive_b,
  // Extra hold capacitance select
  output logic [CAP_W-1:0]       extra_hold_capacitance,
  // Converter core handshake
  output logic                   convert_start,
  output logic                   busy,
  output logic                   second_sample
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic              go;
  logic              charge_phase_level;
  logic              guard_idle_level;
  logic              second_sample_invert;
  logic              dual_sample_enable;
  logic              conv_on;
  logic [LEN_W-1:0]  precharge_length;
  logic [LEN_W-1:0]  sampling_window_length;
  logic [CAP_W-1:0]  cap_select;
  logic [CONV_W-1:0] conv_length;

  cvd_state_type     state;
  cvd_state_type     next_state;
  logic              sample_idx;
  logic              done_pulse;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Effective acquisition length for a given precharge setting
  function automatic logic [LEN_W-1:0] acq_len(
    input logic [LEN_W-1:0] pre_len,
    input logic [LEN_W-1:0] win_len
  );
    if (win_len == '0 && pre_len != '0) begin
      return LEN_MAX;
    end
    return win_len;
  endfunction : acq_len

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         aw_take  = s_axi_awvalid && s_axi_awready;
  wire         w_take   = s_axi_wvalid && s_axi_wready;
  wire         aw_have  = aw_held || aw_take;
  wire         w_have   = w_held || w_take;
  wire         wr_fire  = aw_have && w_have && !s_axi_bvalid;
  wire [7:0]   wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0]  wr_data  = w_held ? w_data : s_axi_wdata;
  wire [3:0]   wr_strb  = w_held ? w_strb : s_axi_wstrb;
  wire         wr_ctrl  = wr_fire && wr_addr == ADDR_CTRL;
  wire         wr_pre   = wr_fire && wr_addr == ADDR_PRE;
  wire         wr_acq   = wr_fire && wr_addr == ADDR_ACQ;
  wire         wr_cap   = wr_fire && wr_addr == ADDR_CAP;
  wire         wr_conv  = wr_fire && wr_addr == ADDR_CONV;
  wire         wr_map   = wr_ctrl || wr_pre || wr_acq || wr_cap
                          || wr_conv || wr_addr == ADDR_STATUS;
  wire [31:0]  ctrl_word = {26'h0, conv_on, dual_sample_enable,
                            second_sample_invert, guard_idle_level,
                            charge_phase_level, go};
  wire [31:0]  ctrl_new = merge_bytes(ctrl_word, wr_data, wr_strb);

  // Address and data latches; accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_held <= 1'b0;
      end else if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (wr_fire) begin
        w_held <= 1'b0;
      end else if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Ready and response handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid;
      s_axi_wready  <= !w_have && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire hw_trigger = special_trigger || restart_trigger;
  wire start_conv = state == ST_IDLE && conv_on
                    && (go || hw_trigger);

  // Software fields; hardware clears go on completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go                     <= 1'b0;
      charge_phase_level     <= 1'b0;
      guard_idle_level       <= 1'b0;
      second_sample_invert   <= 1'b0;
      dual_sample_enable     <= 1'b0;
      conv_on                <= 1'b0;
      precharge_length       <= '0;
      sampling_window_length <= '0;
      cap_select             <= '0;
      conv_length            <= CONV_DEFAULT;
    end else begin
      if (wr_ctrl) begin
        charge_phase_level   <= ctrl_new[CTRL_LEVEL];
        guard_idle_level     <= ctrl_new[CTRL_GIDLE];
        second_sample_invert <= ctrl_new[CTRL_INVERT];
        dual_sample_enable   <= ctrl_new[CTRL_DUAL];
        conv_on              <= ctrl_new[CTRL_ON];
      end
      if (wr_ctrl && ctrl_new[CTRL_GO]) begin
        go <= 1'b1;
      end else if (done_pulse || start_conv && !go) begin
        go <= 1'b0;
      end else if (start_conv) begin
        go <= 1'b1;
      end
      if (wr_pre) begin
        precharge_length <= wr_data[LEN_W-1:0];
      end
      if (wr_acq) begin
        sampling_window_length <= wr_data[LEN_W-1:0];
      end
      if (wr_cap) begin
        cap_select <= wr_data[CAP_W-1:0];
      end
      if (wr_conv) begin
        conv_length <= wr_data[CONV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  wire              pre_en  = precharge_length != '0;
  wire [LEN_W-1:0]  acq_eff = acq_len(precharge_length,
                                      sampling_window_length);
  wire              acq_en  = acq_eff != '0;
  wire              last_sample = !dual_sample_enable || sample_idx;
  wire              timer_exp;
  wire              conv_exp;
  wire              enter_pre  = next_state == ST_PRE && state != ST_PRE;
  wire              enter_acq  = next_state == ST_ACQ && state != ST_ACQ;
  wire              enter_conv = next_state == ST_CONV
                                 && (state != ST_CONV || conv_exp);
  wire [LEN_W-1:0]  timer_len  = enter_pre ? precharge_length : acq_eff;
  wire              next_idx   = start_conv ? 1'b0
                                 : state == ST_CONV && conv_exp ? !last_sample
                                 : sample_idx;
  wire              level_now  = charge_phase_level ^ next_idx;
  assign done_pulse = state == ST_CONV && conv_exp && last_sample;

  // Entry point of a sample sequence
  function automatic cvd_state_type first_phase(
    input logic p_en,
    input logic a_en
  );
    if (p_en) begin
      return ST_PRE;
    end else if (a_en) begin
      return ST_ACQ;
    end
    return ST_CONV;
  endfunction : first_phase

  // Next state selection
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_conv) begin
          next_state = first_phase(pre_en, acq_en);
        end
      end
      ST_PRE: begin
        if (timer_exp) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (timer_exp) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_exp) begin
          next_state = last_sample ? ST_IDLE
                                   : first_phase(pre_en, acq_en);
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State and sample index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= ST_IDLE;
      sample_idx <= 1'b0;
    end else begin
      state      <= next_state;
      sample_idx <= next_idx;
    end
  end

  // Precharge and acquisition length counter
  cvd_phase_timer #(
    .WIDTH   (LEN_W)
  ) u_phase_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (enter_pre || enter_acq),
    .length  (timer_len),
    .expired (timer_exp)
  );

  // Conversion length counter
  cvd_phase_timer #(
    .WIDTH   (CONV_W)
  ) u_conv_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (enter_conv),
    .length  (conv_length),
    .expired (conv_exp)
  );

  // ----------------------------------------------------------------
  // Analog switch, pin and guard outputs
  // ----------------------------------------------------------------
  wire in_pre  = next_state == ST_PRE;
  wire in_acq  = next_state == ST_ACQ;
  wire in_conv = next_state == ST_CONV;
  wire first_pre = enter_pre && !sample_idx && state == ST_IDLE;

  // Registered drive of switches and pin override
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_isolate    <= 1'b0;
      hold_tie_supply <= 1'b0;
      hold_tie_ground <= 1'b0;
      channel_connect <= 1'b0;
      pin_out         <= 1'b0;
      pin_oe          <= 1'b0;
      extra_hold_capacitance <= '0;
    end else begin
      hold_isolate    <= in_pre;
      hold_tie_supply <= in_pre && level_now;
      hold_tie_ground <= in_pre && !level_now;
      // Channel stays on the capacitor when idle; no discharge
      channel_connect <= !in_pre && !in_conv;
      pin_out         <= in_pre && !level_now;
      pin_oe          <= in_pre || !pin_direction_control
                         && next_state == ST_IDLE;
      extra_hold_capacitance <= in_conv ? '0 : cap_select;
    end
  end

  // Guard ring drives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard_drive_a <= 1'b0;
      guard_drive_b <= 1'b0;
    end else if (first_pre || start_conv && !pre_en) begin
      guard_drive_a <= guard_idle_level;
      guard_drive_b <= guard_idle_level;
    end else if (enter_pre && next_idx && second_sample_invert) begin
      guard_drive_a <= !guard_idle_level;
      guard_drive_b <= !guard_idle_level;
    end else if (enter_acq) begin
      guard_drive_a <= !guard_drive_a;
    end
  end

  // Converter handshake outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      convert_start <= 1'b0;
      busy          <= 1'b0;
      second_sample <= 1'b0;
    end else begin
      convert_start <= enter_conv;
      busy          <= next_state != ST_IDLE;
      second_sample <= next_idx;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire        ar_take = s_axi_arvalid && s_axi_arready;
  wire [31:0] status_word = {27'h0, sample_idx, 1'b0, state};
  wire [31:0] rd_word =
    s_axi_araddr == ADDR_CTRL   ? ctrl_word :
    s_axi_araddr == ADDR_PRE    ? {19'h0, precharge_length} :
    s_axi_araddr == ADDR_ACQ    ? {19'h0, sampling_window_length} :
    s_axi_araddr == ADDR_CAP    ? {27'h0, cap_select} :
    s_axi_araddr == ADDR_STATUS ? status_word :
    s_axi_araddr == ADDR_CONV   ? {24'h0, conv_length} : 32'h0;
  wire        rd_map = s_axi_araddr == ADDR_CTRL
                       || s_axi_araddr == ADDR_PRE
                       || s_axi_araddr == ADDR_ACQ
                       || s_axi_araddr == ADDR_CAP
                       || s_axi_araddr == ADDR_STATUS
                       || s_axi_araddr == ADDR_CONV;

  // Read address accept and data return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : cvd_precharge_acq_sequencer

/* verification/cvd_sensor_model.sv */
`timescale 1ns/10ps
module cvd_sensor_model (
  // Clock
  input wire logic         aclk,
  // Pin and guard drives
  input wire logic         pin_out,
  input wire logic         pin_oe,
  input wire logic         guard_drive_a,
  input wire logic         guard_drive_b,
  // Electrode and guard trace levels
  output logic             electrode,
  output logic [1:0]       guard_trace
);
  initial electrode = 1'b0;
  // Driven electrode follows pin, released one has no settled level
  always @(posedge aclk) begin
    if (pin_oe)
      electrode <= pin_out;
    else
      electrode <= ~electrode;
  end
  // Guard trace sees both ring drives
  assign guard_trace = {guard_drive_a, guard_drive_b};
endmodule : cvd_sensor_model

/* verification/cvd_seq_checker.sv */
`timescale 1ns/10ps
module cvd_seq_checker
  import cvd_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Register writes
  input wire logic [7:0]        s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  // Sequencer outputs
  input wire logic              hold_isolate,
  input wire logic              hold_tie_supply,
  input wire logic              hold_tie_ground,
  input wire logic              channel_connect,
  input wire logic              pin_out,
  input wire logic              pin_oe,
  input wire logic              guard_drive_a,
  input wire logic              guard_drive_b,
  input wire logic [CAP_W-1:0]  extra_hold_capacitance,
  input wire logic              convert_start,
  input wire logic              busy,
  input wire logic              second_sample
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [LEN_W-1:0] pre_len;
  logic [LEN_W-1:0] pre_cnt;
  // ----
  // Shadow of precharge length, phase counter
  // ----
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pre_len <= '0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
             && s_axi_wready && s_axi_awaddr == ADDR_PRE)
      pre_len <= s_axi_wdata[LEN_W-1:0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !hold_isolate)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 1'b1;
  end
  // ----
  // Properties
  // ----
  sequence s_pre_end;
    hold_isolate ##1 !hold_isolate;
  endsequence
  a_pre_tie_level: assert property (hold_isolate |->
    hold_tie_supply != hold_tie_ground) else $error("tie level bad");
  a_pin_opposite: assert property (hold_isolate |->
    pin_oe && pin_out == hold_tie_ground) else $error("pin drive bad");
  a_acq_connect: assert property (s_pre_end |-> channel_connect
    && !pin_oe && !hold_tie_supply && !hold_tie_ground)
    else $error("acquisition not connected");
  a_pre_length: assert property (s_pre_end |->
    pre_cnt == pre_len) else $error("precharge length bad");
  a_guard_acq: assert property (s_pre_end |->
    guard_drive_a != $past(guard_drive_a) && $stable(guard_drive_b))
    else $error("guard toggle bad");
  a_guard_first: assert property ($rose(hold_isolate)
    && !second_sample |-> guard_drive_a == guard_drive_b)
    else $error("guard start bad");
  a_conv_no_cap: assert property (convert_start |=>
    extra_hold_capacitance == '0) else $error("cap in conversion");
  a_conv_after_acq: assert property (convert_start |->
    !hold_isolate && !$past(hold_isolate) ##1 !convert_start)
    else $error("conversion start bad");
  a_idle_no_tie: assert property (!busy ##1 !busy |->
    !hold_tie_supply && !hold_tie_ground) else $error("idle tie");
endmodule : cvd_seq_checker

bind cvd_precharge_acq_sequencer cvd_seq_checker cvd_seq_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .hold_isolate(hold_isolate),
  .hold_tie_supply(hold_tie_supply), .hold_tie_ground(hold_tie_ground),
  .channel_connect(channel_connect), .pin_out(pin_out), .pin_oe(pin_oe),
  .guard_drive_a(guard_drive_a), .guard_drive_b(guard_drive_b),
  .extra_hold_capacitance(extra_hold_capacitance),
  .convert_start(convert_start), .busy(busy),
  .second_sample(second_sample)
);

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import cvd_pkg::*;
  logic             aclk, aresetn, spec_trig, rst_trig, pin_dir;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata;
  logic [1:0]       bresp, rresp, guard_trace;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic             iso, tsup, tgnd, chan, pout, poe, ga, gb;
  logic             cstart, busy, ssamp, electrode, lvl, iso_last;
  logic [CAP_W-1:0] cap, cap_last;
  logic [7:0]       obs_q[$];
  int               pre_n, acq_n, errors, total_checks;
  int               pre_q[$], acq_q[$];
  // ----
  // Design and far side
  // ----
  cvd_precharge_acq_sequencer cvd_precharge_acq_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .special_trigger(spec_trig),
    .restart_trigger(rst_trig), .pin_direction_control(pin_dir),
    .hold_isolate(iso), .hold_tie_supply(tsup), .hold_tie_ground(tgnd),
    .channel_connect(chan), .pin_out(pout), .pin_oe(poe),
    .guard_drive_a(ga), .guard_drive_b(gb),
    .extra_hold_capacitance(cap), .convert_start(cstart), .busy(busy),
    .second_sample(ssamp));
  cvd_sensor_model cvd_sensor_model_inst (
    .aclk(aclk), .pin_out(pout), .pin_oe(poe), .guard_drive_a(ga),
    .guard_drive_b(gb), .electrode(electrode),
    .guard_trace(guard_trace));
  // ----
  // Clock, watchdog, phase monitor
  // ----
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    #1000000;
    errors++;
    finish_test;
  end
  always @(posedge aclk) begin
    cap_last <= cap;
    iso_last <= iso;
    if (iso_last && !iso) check(electrode, !lvl);
    if (iso) begin
      pre_n <= pre_n + 1;
      lvl <= tsup;
    end
    acq_n <= (iso || !busy) ? 0 : acq_n + 1;
    if (cstart) begin
      pre_q.push_back(pre_n);
      acq_q.push_back(acq_n);
      obs_q.push_back({lvl, guard_trace, cap_last});
      pre_n <= 0;
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    bit aw_ok = 0, w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read
  task automatic wait_done;
    int k = 0;
    repeat (3) @(posedge aclk);
    while (busy !== 1'b0 && k < 10000) begin
      @(posedge aclk);
      k++;
    end
    check(32'(k < 10000), 32'h1);
  endtask : wait_done
  // ----
  // Scenarios
  // ----
  task automatic test_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(ADDR_CONV, d, r);
    check(d, 32'(CONV_DEFAULT));
    axi_read(ADDR_STATUS, d, r);
    check(d, 32'h0);
    axi_write(ADDR_CAP, 32'h5, r);
    axi_read(ADDR_CAP, d, r);
    check(d, 32'h5);
    axi_read(8'h18, d, r);
    check(r, RESP_SLVERR);
    check(d, 32'h0);
    axi_write(8'h18, 32'h1, r);
    check(r, RESP_SLVERR);
  endtask : test_regs
  task automatic run(input logic lv, gi, iv, du, input int p, a);
    logic [1:0]  r;
    logic [31:0] c;
    c = (32'h1 << CTRL_ON) | (32'h1 << CTRL_GO) | (32'(lv) << CTRL_LEVEL)
      | (32'(gi) << CTRL_GIDLE) | (32'(iv) << CTRL_INVERT)
      | (32'(du) << CTRL_DUAL);
    pre_q.delete();
    acq_q.delete();
    obs_q.delete();
    axi_write(ADDR_PRE, 32'(p), r);
    axi_write(ADDR_ACQ, 32'(a), r);
    axi_write(ADDR_CTRL, c, r);
    wait_done;
    check(pre_q.size(), du ? 2 : 1);
    for (int i = 0; i < pre_q.size(); i++) begin
      check(pre_q[i], p);
      if (p != 0) begin
        check(acq_q[i], a == 0 ? 8191 : a);
        check(obs_q[i][7], lv ^ i[0]);
        check(obs_q[i][6], i ? gi : !gi);
        check(obs_q[i][5], (i && iv) ? !gi : gi);
        check(obs_q[i][4:0], 32'h5);
      end
    end
  endtask : run
  task automatic test_trig;
    logic [1:0] r;
    pin_dir <= 1'b0;
    axi_write(ADDR_CTRL, 32'h1 << CTRL_ON, r);
    axi_write(ADDR_PRE, 32'h2, r);
    axi_write(ADDR_ACQ, 32'h3, r);
    check(poe, 1'b1);
    pre_q.delete();
    spec_trig <= 1'b1;
    @(posedge aclk);
    spec_trig <= 1'b0;
    wait_done;
    rst_trig <= 1'b1;
    @(posedge aclk);
    rst_trig <= 1'b0;
    wait_done;
    check(pre_q.size(), 2);
    check(pre_q[1], 2);
    pin_dir <= 1'b1;
  endtask : test_trig
  // ----
  // Main sequence
  // ----
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {spec_trig, rst_trig, awaddr, araddr, wdata} = '0;
    pin_dir = 1'b1;
    aresetn = 1'b0;
    pre_n = 0;
    acq_n = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    test_regs;
    run(1'b1, 1'b0, 1'b0, 1'b0, 5, 7);
    run(1'b0, 1'b1, 1'b1, 1'b1, 3, 2);
    run(1'b1, 1'b1, 1'b0, 1'b1, 1, 1);
    run(1'b0, 1'b0, 1'b0, 1'b0, 4, 0);
    run(1'b1, 1'b0, 1'b0, 1'b0, 0, 6);
    run(1'b1, 1'b0, 1'b0, 1'b0, 0, 0);
    test_trig;
    finish_test;
  end
endmodule : tb_top
